// File: verilog/phy_mgmt_status.sv
// Management frame engine serving the basic status register
//
// Contract
// - 100BASE-TX full and half ability read 1
// - 10BASE-Te full and half ability read 1
// - T4 and T2 ability bits read 0
// - Extended status register present reads 1
// - Reserved bit reads 0, written 0
// - Short frames accepted after one full preamble
// - Auto-negotiation complete bit follows process
// - Remote fault latches high until read or reset
// - Auto-negotiation ability reads 1
// - Link bit latches low, sets after read
// - Jabber latches high until read or reset
// - Extended register capability reads 1
`include "phy_status_consts.svh"
`default_nettype none
module phy_mgmt_status
   import phy_status_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = `BLS_PHY_ADDR_DEF
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Management pins
   input wire logic i_mdc,
   input wire logic i_mdio,
   output logic o_mdio,
   output logic o_mdio_oe,
   // Status events from the line logic
   input wire logic i_an_done,
   input wire logic i_link_good,
   input wire logic i_remote_fault,
   input wire logic i_jabber
);
   status_read_if rd_if ();

   // Pin synchronisers and edge detect state
   logic mdc_s1_r, mdc_s2_r, mdc_s3_r;
   logic mdio_s1_r, mdio_s2_r;
   logic mdc_rise;
   logic bit_in;

   // Frame engine state
   mgmt_state_t state_r, state_nxt;
   logic [5:0] ones_r, ones_nxt;
   logic pre_ok_r, pre_ok_nxt;
   logic [4:0] cnt_r, cnt_nxt;
   logic [11:0] hdr_r, hdr_nxt;
   logic [15:0] shift_r, shift_nxt;
   logic mdio_r, mdio_nxt;
   logic oe_r, oe_nxt;
   logic snap_r, snap_nxt;
   logic rel_r, rel_nxt;
   logic [11:0] hdr_full;
   logic [1:0] op;
   logic [4:0] phy_sel;
   logic [4:0] reg_sel;

   // Two flops on each pin before use; third flop only for the edge
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         mdc_s1_r <= 1'h0;
         mdc_s2_r <= 1'h0;
         mdc_s3_r <= 1'h0;
         mdio_s1_r <= 1'h1;
         mdio_s2_r <= 1'h1;
      end else begin
         mdc_s1_r <= i_mdc;
         mdc_s2_r <= mdc_s1_r;
         mdc_s3_r <= mdc_s2_r;
         mdio_s1_r <= i_mdio;
         mdio_s2_r <= mdio_s1_r;
      end
   end

   // Bits are taken on the management clock rising edge
   assign mdc_rise = mdc_s2_r & ~mdc_s3_r;
   assign bit_in = mdio_s2_r;

   // Header fields once the last header bit has arrived
   assign hdr_full = {hdr_r[10:0], bit_in};
   assign op = hdr_full[11:10];
   assign phy_sel = hdr_full[9:5];
   assign reg_sel = hdr_full[4:0];

   // Frame engine next state
   always_comb begin
      state_nxt = state_r;
      ones_nxt = ones_r;
      pre_ok_nxt = pre_ok_r;
      cnt_nxt = cnt_r;
      hdr_nxt = hdr_r;
      shift_nxt = shift_r;
      mdio_nxt = mdio_r;
      oe_nxt = oe_r;
      snap_nxt = 1'h0;
      rel_nxt = 1'h0;
      if (mdc_rise) begin
         case (state_r)
            S_IDLE: begin
               if (bit_in) begin
                  // Count preamble ones, saturating
                  if (ones_r != `MF_PREAMBLE_LEN) begin
                     ones_nxt = ones_r + 6'h01;
                  end
               end else begin
                  ones_nxt = 6'h00;
                  // Start bit: needs one full preamble since last error
                  if (pre_ok_r || ones_r == `MF_PREAMBLE_LEN) begin
                     pre_ok_nxt = 1'h1;
                     state_nxt = S_START;
                  end
               end
            end
            S_START: begin
               // Second start bit must be one
               if (bit_in) begin
                  cnt_nxt = 5'h00;
                  state_nxt = S_HDR;
               end else begin
                  state_nxt = S_IDLE;
               end
            end
            S_HDR: begin
               hdr_nxt = hdr_full;
               cnt_nxt = cnt_r + 5'h01;
               if (cnt_r == `MF_HDR_BITS - 5'h01) begin
                  cnt_nxt = 5'h00;
                  if (op == `MF_OP_READ) begin
                     if (phy_sel == PHY_ADDR && reg_sel == `BLS_REG_ADDR) begin
                        // Snapshot value before any release
                        snap_nxt = 1'h1;
                        state_nxt = S_TA_RD;
                     end else begin
                        // Not ours: let the frame pass by
                        state_nxt = S_SKIP;
                     end
                  end else if (op == `MF_OP_WRITE) begin
                     state_nxt = S_TA_WR;
                  end else begin
                     // Invalid opcode: full preamble needed again
                     pre_ok_nxt = 1'h0;
                     state_nxt = S_IDLE;
                  end
               end
            end
            S_TA_RD: begin
               // Drive zero in the second turnaround bit
               mdio_nxt = 1'h0;
               oe_nxt = 1'h1;
               cnt_nxt = 5'h00;
               state_nxt = S_RD;
            end
            S_RD: begin
               if (cnt_r == `MF_DATA_BITS) begin
                  // Read complete: release the latches now
                  oe_nxt = 1'h0;
                  mdio_nxt = 1'h1;
                  rel_nxt = 1'h1;
                  state_nxt = S_IDLE;
               end else begin
                  mdio_nxt = shift_r[15];
                  shift_nxt = {shift_r[14:0], 1'h0};
                  cnt_nxt = cnt_r + 5'h01;
               end
            end
            S_TA_WR: begin
               cnt_nxt = cnt_r + 5'h01;
               if (cnt_r == `MF_TA_BITS - 5'h01) begin
                  cnt_nxt = 5'h00;
                  if (bit_in) begin
                     // Invalid turnaround: full preamble needed again
                     pre_ok_nxt = 1'h0;
                     state_nxt = S_IDLE;
                  end else begin
                     // Written data is discarded; register is read-only
                     state_nxt = S_SKIP;
                  end
               end
            end
            S_SKIP: begin
               // Skip data bits (plus turnaround for foreign reads)
               cnt_nxt = cnt_r + 5'h01;
               if (cnt_r == `MF_DATA_BITS + `MF_TA_BITS - 5'h01 ||
                   (hdr_r[11:10] == `MF_OP_WRITE && cnt_r == `MF_DATA_BITS - 5'h01)) begin
                  cnt_nxt = 5'h00;
                  state_nxt = S_IDLE;
               end
            end
            default: begin
               state_nxt = S_IDLE;
               oe_nxt = 1'h0;
               mdio_nxt = 1'h1;
            end
         endcase
      end
      // Load the shift register one cycle after the snapshot
      if (snap_r) begin
         shift_nxt = rd_if.value;
      end
   end

   // Frame engine registers
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_r <= S_IDLE;
         ones_r <= 6'h00;
         pre_ok_r <= 1'h0;
         cnt_r <= 5'h00;
         hdr_r <= 12'h000;
         shift_r <= 16'h0000;
         mdio_r <= 1'h1;
         oe_r <= 1'h0;
         snap_r <= 1'h0;
         rel_r <= 1'h0;
      end else begin
         state_r <= state_nxt;
         ones_r <= ones_nxt;
         pre_ok_r <= pre_ok_nxt;
         cnt_r <= cnt_nxt;
         hdr_r <= hdr_nxt;
         shift_r <= shift_nxt;
         mdio_r <= mdio_nxt;
         oe_r <= oe_nxt;
         snap_r <= snap_nxt;
         rel_r <= rel_nxt;
      end
   end

   // Access strobes to the register and pin outputs
   assign rd_if.snap = snap_r;
   assign rd_if.release_rd = rel_r;
   assign o_mdio = mdio_r;
   assign o_mdio_oe = oe_r;

   // Status register with its latches
   basic_link_status u_status (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .rd(rd_if.regs),
      .i_an_done(i_an_done),
      .i_link_good(i_link_good),
      .i_remote_fault(i_remote_fault),
      .i_jabber(i_jabber)
   );
endmodule // phy_mgmt_status
`default_nettype wire

// File: verilog/phy_status_consts.svh
// Constants for the management status register block
`ifndef PHY_STATUS_CONSTS_SVH
`define PHY_STATUS_CONSTS_SVH

// Register address of the status register on the management bus
`define BLS_REG_ADDR 5'h01
// Default station address of this transceiver
`define BLS_PHY_ADDR_DEF 5'h00

// Field positions inside the status register
`define BLS_T4_BIT 4'hf
`define BLS_TX_FD_BIT 4'he
`define BLS_TX_HD_BIT 4'hd
`define BLS_TE_FD_BIT 4'hc
`define BLS_TE_HD_BIT 4'hb
`define BLS_T2_FD_BIT 4'ha
`define BLS_T2_HD_BIT 4'h9
`define BLS_EXT_STAT_BIT 4'h8
`define BLS_RSVD_BIT 4'h7
`define BLS_SHORT_FRAME_BIT 4'h6
`define BLS_AN_DONE_BIT 4'h5
`define BLS_RFAULT_BIT 4'h4
`define BLS_AN_ABLE_BIT 4'h3
`define BLS_LINK_BIT 4'h2
`define BLS_JABBER_BIT 4'h1
`define BLS_EXT_CAP_BIT 4'h0

// Reset values of the live and latched bits
`define BLS_AN_DONE_RST 1'h0
`define BLS_RFAULT_RST 1'h0
`define BLS_LINK_RST 1'h0
`define BLS_JABBER_RST 1'h0

// Management frame layout
`define MF_PREAMBLE_LEN 6'h20
`define MF_HDR_BITS 5'h0c
`define MF_DATA_BITS 5'h10
`define MF_TA_BITS 5'h02
`define MF_OP_READ 2'h2
`define MF_OP_WRITE 2'h1

`endif

// File: verilog/phy_status_pkg.sv
// Types shared by the management status register block
`default_nettype none
package phy_status_pkg;
   // Management frame receiver states, one-hot
   typedef enum logic [6:0] {
      S_IDLE  = 7'h01,
      S_START = 7'h02,
      S_HDR   = 7'h04,
      S_TA_RD = 7'h08,
      S_RD    = 7'h10,
      S_TA_WR = 7'h20,
      S_SKIP  = 7'h40
   } mgmt_state_t;
endpackage
`default_nettype wire

// File: verilog/status_read_if.sv
// Link between the frame engine and the status register
`default_nettype none
interface status_read_if;
   logic snap;
   logic release_rd;
   logic [15:0] value;
   // Frame engine side
   modport engine (output snap, output release_rd, input value);
   // Register side
   modport regs (input snap, input release_rd, output value);
endinterface
`default_nettype wire

// File: verilog/basic_link_status.sv
// Status register with fixed, live and latched bits
`include "phy_status_consts.svh"
`default_nettype none
module basic_link_status
   import phy_status_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Frame engine access
   status_read_if.regs rd,
   // Status events from the line logic
   input wire logic i_an_done,
   input wire logic i_link_good,
   input wire logic i_remote_fault,
   input wire logic i_jabber
);
   logic an_done_r, an_done_nxt;
   logic rfault_r, rfault_nxt;
   logic rfault_new_r, rfault_new_nxt;
   logic jab_r, jab_nxt;
   logic jab_new_r, jab_new_nxt;
   logic link_r, link_nxt;
   logic link_fail_r, link_fail_nxt;

   // Latch updates; a new event always wins over a release
   always_comb begin
      an_done_nxt = i_an_done;
      rfault_nxt = rfault_r | i_remote_fault;
      jab_nxt = jab_r | i_jabber;
      link_nxt = link_r & i_link_good;
      // Events after the snapshot are kept for the release
      rfault_new_nxt = rfault_new_r | i_remote_fault;
      jab_new_nxt = jab_new_r | i_jabber;
      link_fail_nxt = link_fail_r | ~i_link_good;
      if (rd.snap) begin
         rfault_new_nxt = i_remote_fault;
         jab_new_nxt = i_jabber;
         link_fail_nxt = ~i_link_good;
      end
      if (rd.release_rd) begin
         rfault_nxt = rfault_new_r | i_remote_fault;
         jab_nxt = jab_new_r | i_jabber;
         link_nxt = i_link_good & ~link_fail_r;
      end
   end

   // Register stage
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         an_done_r <= `BLS_AN_DONE_RST;
         rfault_r <= `BLS_RFAULT_RST;
         rfault_new_r <= `BLS_RFAULT_RST;
         jab_r <= `BLS_JABBER_RST;
         jab_new_r <= `BLS_JABBER_RST;
         link_r <= `BLS_LINK_RST;
         link_fail_r <= 1'h0;
      end else begin
         an_done_r <= an_done_nxt;
         rfault_r <= rfault_nxt;
         rfault_new_r <= rfault_new_nxt;
         jab_r <= jab_nxt;
         jab_new_r <= jab_new_nxt;
         link_r <= link_nxt;
         link_fail_r <= link_fail_nxt;
      end
   end

   // Read value assembly
   always_comb begin
      rd.value = 16'h0000;
      rd.value[`BLS_T4_BIT] = 1'h0;
      rd.value[`BLS_TX_FD_BIT] = 1'h1;
      rd.value[`BLS_TX_HD_BIT] = 1'h1;
      rd.value[`BLS_TE_FD_BIT] = 1'h1;
      rd.value[`BLS_TE_HD_BIT] = 1'h1;
      rd.value[`BLS_T2_FD_BIT] = 1'h0;
      rd.value[`BLS_T2_HD_BIT] = 1'h0;
      rd.value[`BLS_EXT_STAT_BIT] = 1'h1;
      rd.value[`BLS_RSVD_BIT] = 1'h0;
      rd.value[`BLS_SHORT_FRAME_BIT] = 1'h1;
      rd.value[`BLS_AN_DONE_BIT] = an_done_r;
      rd.value[`BLS_RFAULT_BIT] = rfault_r;
      rd.value[`BLS_AN_ABLE_BIT] = 1'h1;
      rd.value[`BLS_LINK_BIT] = link_r;
      rd.value[`BLS_JABBER_BIT] = jab_r;
      rd.value[`BLS_EXT_CAP_BIT] = 1'h1;
   end
endmodule // basic_link_status
`default_nettype wire

// File: test/phy_mgmt_status_assertions.sv
// Pin-level checks of the management status block
`default_nettype none
module phy_mgmt_status_assertions (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Management pins
   input wire logic i_mdc,
   input wire logic i_mdio,
   input wire logic o_mdio,
   input wire logic o_mdio_oe,
   // Status events
   input wire logic i_an_done,
   input wire logic i_link_good,
   input wire logic i_remote_fault,
   input wire logic i_jabber
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] ONES = 16'h7949;
   localparam logic [15:0] ZEROS = 16'h8680;
   logic mdc_q_r, mdc_q_nxt;
   logic [4:0] cnt_r, cnt_nxt;
   logic [3:0] since_r, since_nxt, idx;
   // Rises seen while driving, cycles since the last rise
   always_comb begin
      mdc_q_nxt = i_mdc;
      cnt_nxt = o_mdio_oe ? cnt_r + {4'h0, i_mdc & ~mdc_q_r} : 5'h00;
      since_nxt = (i_mdc & ~mdc_q_r) ? 4'h0 : since_r + {3'h0, since_r != 4'hf};
      idx = 4'h0 - cnt_r[3:0];
   end
   // Helper registers
   always_ff @(posedge i_clk) begin
      mdc_q_r <= i_srst ? 1'b0 : mdc_q_nxt;
      cnt_r <= i_srst ? 5'h00 : cnt_nxt;
      since_r <= i_srst ? 4'hf : since_nxt;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   property p_reset_idle; $fell(i_srst) |-> (o_mdio && !o_mdio_oe) [*3]; endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("pins busy after reset");
   property p_idle_high; !o_mdio_oe |-> o_mdio; endproperty
   a_idle_high: assert property (p_idle_high) else $error("idle data not high");
   property p_change_win;
      ($changed(o_mdio) || $changed(o_mdio_oe)) |-> since_r inside {[1:6]};
   endproperty
   a_change_win: assert property (p_change_win) else $error("output moved off a rise");
   property p_ta_zero; $rose(o_mdio_oe) |-> !o_mdio; endproperty
   a_ta_zero: assert property (p_ta_zero) else $error("turnaround not low");
   property p_oe_hold; $rose(o_mdio_oe) |-> o_mdio_oe [*8]; endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("drive dropped early");
   property p_rise_count; $fell(o_mdio_oe) |-> cnt_r == 5'h11; endproperty
   a_rise_count: assert property (p_rise_count) else $error("wrong data length");
   sequence s_mid_bit; o_mdio_oe && $fell(i_mdc) && cnt_r inside {[1:16]}; endsequence
   property p_ones; s_mid_bit ##0 ONES[idx] |-> o_mdio; endproperty
   a_ones: assert property (p_ones) else $error("fixed one bit low");
   property p_zeros; s_mid_bit ##0 ZEROS[idx] |-> !o_mdio; endproperty
   a_zeros: assert property (p_zeros) else $error("fixed zero bit high");
   c_answer: cover property ($fell(o_mdio_oe));
   c_jabber: cover property ($rose(i_jabber));
   c_link_drop: cover property ($fell(i_link_good));
endmodule // phy_mgmt_status_assertions
bind phy_mgmt_status phy_mgmt_status_assertions phy_mgmt_status_assertions_inst (
   .i_clk(i_clk), .i_srst(i_srst), .i_mdc(i_mdc), .i_mdio(i_mdio), .o_mdio(o_mdio),
   .o_mdio_oe(o_mdio_oe), .i_an_done(i_an_done), .i_link_good(i_link_good),
   .i_remote_fault(i_remote_fault), .i_jabber(i_jabber));
`default_nettype wire

// File: test/mdio_station.sv
// Station management controller model driving management frames
`default_nettype none
module mdio_station (
   // Clock
   input wire logic i_clk,
   // Management pins
   input wire logic i_mdio,
   output logic o_mdc,
   output logic o_mdio,
   output logic o_mdio_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 5;
   // Clock parked low, line released
   initial begin
      o_mdc = 1'b0;
      o_mdio = 1'b1;
      o_mdio_oe = 1'b0;
   end
   // One bit: drive while low, sample the wire just before the rise
   task automatic bit_cycle(input logic drv, input logic val, output logic seen);
      @(posedge i_clk);
      o_mdio_oe <= drv;
      o_mdio <= val;
      repeat (HALF) @(posedge i_clk);
      seen = i_mdio;
      o_mdc <= 1'b1;
      repeat (HALF) @(posedge i_clk);
      o_mdc <= 1'b0;
   endtask
   // Preamble, start, opcode, addresses, turnaround and data
   task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] phy,
         input logic [4:0] rg, input logic [1:0] ta, input logic [15:0] wd,
         output logic [15:0] rd);
      logic [31:0] bits;
      logic s;
      bits = {2'b01, op, phy, rg, ta, wd};
      for (int i = 0; i < pre; i++) bit_cycle(1'b1, 1'b1, s);
      for (int i = 0; i < 32; i++) begin
         bit_cycle(i < 14 || op != 2'b10, bits[31-i], s);
         if (i >= 16) rd[31-i] = s;
      end
      @(posedge i_clk);
      o_mdio_oe <= 1'b0;
   endtask
endmodule // mdio_station
`default_nettype wire

// File: test/tb_phy_mgmt_status.sv
// Testbench reading the status register over management frames
`default_nettype none
module tb_phy_mgmt_status;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] FIX = 16'h7949;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic an_done = 1'b0;
   logic link_good = 1'b1;
   logic [1:0] ev = 2'b00;
   logic mdc, st_out, st_oe, dio, dut_out, dut_oe;
   logic [15:0] rd;
   int num_errors = 0;
   int num_checks = 0;
   // Clock and pulled-up data wire
   always #2 clk = ~clk;
   assign dio = dut_oe ? dut_out : (st_oe ? st_out : 1'b1);
   phy_mgmt_status phy_mgmt_status_inst (.i_clk(clk), .i_srst(srst), .i_mdc(mdc),
      .i_mdio(dio), .o_mdio(dut_out), .o_mdio_oe(dut_oe), .i_an_done(an_done),
      .i_link_good(link_good), .i_remote_fault(ev[1]), .i_jabber(ev[0]));
   mdio_station mdio_station_inst (.i_clk(clk), .i_mdio(dio), .o_mdc(mdc), .o_mdio(st_out),
      .o_mdio_oe(st_oe));
   // Compare and count
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Verdict
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Register read and event pulse
   task automatic rd_reg(input int pre, input logic [4:0] phy, input logic [4:0] rg);
      mdio_station_inst.frame(pre, 2'b10, phy, rg, 2'b10, 16'h0000, rd);
   endtask
   task automatic pulse(input logic [1:0] m);
      @(posedge clk) ev <= m;
      @(posedge clk) ev <= 2'b00;
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      rd_reg(0, 5'h00, 5'h01);
      check("no preamble", rd, 16'hffff);
      rd_reg(32, 5'h00, 5'h01);
      check("after reset", rd, FIX);
      rd_reg(0, 5'h00, 5'h01);
      check("link set", rd, FIX | 16'h0004);
      pulse(2'b11);
      rd_reg(0, 5'h00, 5'h01);
      check("faults latched", rd, FIX | 16'h0016);
      rd_reg(0, 5'h00, 5'h01);
      check("faults released", rd, FIX | 16'h0004);
      @(posedge clk) link_good <= 1'b0;
      @(posedge clk) link_good <= 1'b1;
      rd_reg(0, 5'h00, 5'h01);
      check("link dropped", rd, FIX);
      @(posedge clk) an_done <= 1'b1;
      rd_reg(0, 5'h00, 5'h01);
      check("an done", rd, FIX | 16'h0024);
      fork
         rd_reg(0, 5'h00, 5'h01);
         begin
            repeat (250) @(posedge clk);
            pulse(2'b01);
         end
      join
      check("event in read", rd, FIX | 16'h0024);
      rd_reg(0, 5'h00, 5'h01);
      check("event kept", rd, FIX | 16'h0026);
      mdio_station_inst.frame(0, 2'b01, 5'h00, 5'h01, 2'b10, 16'h0000, rd);
      rd_reg(0, 5'h00, 5'h01);
      check("write ignored", rd, FIX | 16'h0024);
      rd_reg(0, 5'h03, 5'h01);
      check("other station", rd, 16'hffff);
      rd_reg(0, 5'h00, 5'h00);
      check("other register", rd, 16'hffff);
      mdio_station_inst.frame(0, 2'b11, 5'h00, 5'h01, 2'b10, 16'h0000, rd);
      rd_reg(0, 5'h00, 5'h01);
      check("bad opcode", rd, 16'hffff);
      rd_reg(32, 5'h00, 5'h01);
      check("preamble again", rd, FIX | 16'h0024);
      // Write with a high second turnaround bit aborts the frame
      mdio_station_inst.frame(0, 2'b01, 5'h00, 5'h01, 2'b11, 16'h0000, rd);
      rd_reg(0, 5'h00, 5'h01);
      check("bad turnaround", rd, 16'hffff);
      rd_reg(32, 5'h00, 5'h01);
      check("preamble after turnaround", rd, FIX | 16'h0024);
      pulse(2'b10);
      @(posedge clk) srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      rd_reg(32, 5'h00, 5'h01);
      check("second reset", rd, FIX | 16'h0020);
      close_out();
   end
   // Watchdog
   initial begin
      #100000;
      num_errors++;
      close_out();
   end
endmodule // tb_phy_mgmt_status
`default_nettype wire
